// file: rtl/cku_defines.svh
// Offsets, field positions, reset values and timing counts of the checksum unit
`ifndef CKU_DEFINES_SVH
`define CKU_DEFINES_SVH

// Special function register addresses
`define CKU_ADDR_OPERATION_CONTROL 8'hEF
`define CKU_ADDR_BYTE_INDEX        8'hFC
`define CKU_ADDR_DATA_WINDOW       8'hFD

// Control register fields
`define CKU_CTL_SCAN_START_BIT     0
`define CKU_CTL_PRESET_BIT         1

// Index values of result bytes
`define CKU_IDX_BYTE0              2'h0
`define CKU_IDX_BYTE1              2'h1
`define CKU_IDX_BYTE2              2'h2
`define CKU_IDX_BYTE3              2'h3

// Reset values and checksum model
`define CKU_INDEX_RESET            8'h00
`define CKU_ACC_PRESET             32'hFFFFFFFF
`define CKU_POLY                   32'h04C11DB7

// Scan ranges in bytes, selected by the application area size field
`define CKU_SCAN_LEN_FULL          17'h10000
`define CKU_SCAN_LEN_LESS_1K       17'h0FC00
`define CKU_SCAN_LEN_LESS_2K       17'h0F800
`define CKU_SCAN_START_ADDR        16'h0000

// Bit count on the last of a byte's eight clocks, one bit per clock
`define CKU_BYTE_CYCLES            3'h7

`endif

// file: rtl/cku_pkg.sv
// Types shared by the checksum unit
package cku_pkg;

	typedef enum logic [1:0] {
		CKU_IDLE  = 2'b00,
		CKU_FETCH = 2'b01,
		CKU_LOAD  = 2'b10,
		CKU_SHIFT = 2'b11
	} cku_state_t;

	// One access from the CPU special function register port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cku_sfr_req_t;

	// Program flash read port
	typedef struct packed {
		logic        rd_en;
		logic [15:0] addr;
	} cku_flash_req_t;

	// Whole state of the unit
	typedef struct packed {
		cku_state_t  st;
		logic        scan;
		logic [2:0]  bit_cnt;
		logic [7:0]  sh;
		logic [31:0] acc;
		logic [7:0]  idx;
		logic [15:0] faddr;
		logic [16:0] rem;
		logic [7:0]  rdata;
	} cku_regs_t;

endpackage

// file: rtl/cku_bit_step.sv
// One MSB-first bit step of the 32-bit checksum, no reflection
`timescale 1ns/100ps
`default_nettype none
`include "cku_defines.svh"

module cku_bit_step
	import cku_pkg::*;
(
	input  wire logic [31:0] crc,
	input  wire logic        din,
	output logic      [31:0] crc_next
);

	// Shift left, fold the polynomial in when the outgoing bit differs from data
	assign crc_next = {crc[30:0], 1'b0} ^ ({32{crc[31] ^ din}} & `CKU_POLY);

endmodule // cku_bit_step
`default_nettype wire

// file: rtl/cku_top.sv
// Checksum unit: SFR window, byte feed mode and program flash scan mode
// Behaviour
// - Writing one to the preset bit while the unit is idle loads the accumulator with all ones.
// - Writing one to control bit 0 while the unit is idle starts a flash scan; zero does nothing.
// - Index register FCH selects which result byte window FDH reaches.
// - Index 3 gives bits 31..24, index 0 gives bits 7..0, in order.
// - Each byte written to the window while the unit is idle is folded into the accumulator.
// - Window writes supply data; window reads return the indexed result byte.
// - Each window read increments the index, wrapping within 0 to 3.
// - A running flash scan holds the CPU idle.
// - A flash scan presets the accumulator to all ones first.
// - Scan starts at 0000H and skips the top area chosen by the size field.
// - When the scan ends the CPU is released and the result is readable.
// - Checksum is 32-bit MPEG-2: all-ones start, no final xor, MSB first.
// - One data byte takes eight system clocks.
// - A full 64 KB scan takes about 16.4 ms at 32 MHz.
`timescale 1ns/100ps
`default_nettype none
`include "cku_defines.svh"

module cku_top
	import cku_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst_b,
	input  wire logic           ce,
	input  wire cku_sfr_req_t   sfr_req,
	output logic         [7:0]  sfr_rdata,
	input  wire logic    [1:0]  app_area_size_field,
	output cku_flash_req_t      flash_req,
	input  wire logic    [7:0]  flash_rdata,
	output logic                cpu_idle
);

	// Register map seen by the CPU:
	//   EF control: bit 1 presets, bit 0 starts a scan; bits 7 and 6 are not ours
	//   FC byte index: bits 1..0 pick the byte, all eight read back; a window read steps bits 1..0 and clears the rest
	//   FD window: writes feed a byte, reads return the indexed result byte

	cku_regs_t   r_q;
	cku_regs_t   r_d;
	logic [31:0] step_crc;
	logic        wr_ctl;
	logic        wr_idx;
	logic        wr_win;
	logic        rd_win;
	logic        rd_idx;
	logic        rd_ctl;
	logic [16:0] scan_len;
	logic [7:0]  sel_byte;
	logic        unit_idle;
	logic        take_preset;
	logic        take_start;
	logic        take_byte;
	logic        byte_done;
	logic        more_bytes;

	// Address decode of the special function register port
	assign wr_ctl = sfr_req.wr && (sfr_req.addr == `CKU_ADDR_OPERATION_CONTROL);
	assign wr_idx = sfr_req.wr && (sfr_req.addr == `CKU_ADDR_BYTE_INDEX);
	assign wr_win = sfr_req.wr && (sfr_req.addr == `CKU_ADDR_DATA_WINDOW);
	assign rd_ctl = sfr_req.rd && (sfr_req.addr == `CKU_ADDR_OPERATION_CONTROL);
	assign rd_idx = sfr_req.rd && (sfr_req.addr == `CKU_ADDR_BYTE_INDEX);
	assign rd_win = sfr_req.rd && (sfr_req.addr == `CKU_ADDR_DATA_WINDOW);

	// Strobes an idle unit accepts; a busy unit drops them silently
	assign unit_idle   = (r_q.st == CKU_IDLE);
	assign take_preset = unit_idle && wr_ctl && sfr_req.wdata[`CKU_CTL_PRESET_BIT];
	assign take_start  = unit_idle && wr_ctl && sfr_req.wdata[`CKU_CTL_SCAN_START_BIT];
	assign take_byte   = unit_idle && wr_win;

	// Last bit of a byte, and whether the scan still has bytes to fetch
	assign byte_done  = (r_q.st == CKU_SHIFT) && (r_q.bit_cnt == `CKU_BYTE_CYCLES);
	assign more_bytes = r_q.scan && (r_q.rem != 17'h00000);

	// Shared bit step, fed MSB first from the byte shifter
	cku_bit_step u_step (
		.crc      (r_q.acc),
		.din      (r_q.sh[7]),
		.crc_next (step_crc)
	);

	// Scan length from the application area size; the top area is never read
	always_comb begin
		case (app_area_size_field)
			2'b00:   scan_len = `CKU_SCAN_LEN_FULL;
			2'b01:   scan_len = `CKU_SCAN_LEN_LESS_1K;
			2'b10:   scan_len = `CKU_SCAN_LEN_LESS_2K;
			2'b11:   scan_len = `CKU_SCAN_LEN_FULL;
			default: scan_len = `CKU_SCAN_LEN_FULL;
		endcase
	end

	// Result byte picked by the low index bits
	always_comb begin
		case (r_q.idx[1:0])
			`CKU_IDX_BYTE3: sel_byte = r_q.acc[31:24];
			`CKU_IDX_BYTE2: sel_byte = r_q.acc[23:16];
			`CKU_IDX_BYTE1: sel_byte = r_q.acc[15:8];
			`CKU_IDX_BYTE0: sel_byte = r_q.acc[7:0];
			default:        sel_byte = r_q.acc[7:0];
		endcase
	end

	// Next state of the whole unit
	// Scan pacing: two clocks to fetch the first byte, then eight per byte,
	// the next byte loading on the last bit; a full flash costs 2 + 8 * 65536
	// clocks, a little over 16 ms at 32 MHz, all of it with the CPU idle
	always_comb begin
		r_d = r_q;

		// Index register: plain store, or step after a window read
		if (wr_idx) begin
			r_d.idx = sfr_req.wdata;
		end else if (rd_win) begin
			r_d.idx = {6'h00, r_q.idx[1:0] + 2'h1};
		end

		// Reads answer one cycle later from a flop; window never echoes written data
		if (rd_win) begin
			r_d.rdata = sel_byte;
		end else if (rd_idx) begin
			// All eight stored index bits read back
			r_d.rdata = r_q.idx;
		end else if (rd_ctl) begin
			// Strobes read back as zero; bit 0 shows a scan in progress
			r_d.rdata = {6'h00, 1'b0, r_q.scan};
		end else if (sfr_req.rd) begin
			r_d.rdata = 8'h00;
		end

		case (r_q.st)
			CKU_IDLE: begin
				// Preset strobe; taken only between bytes so no fold is corrupted
				if (take_preset) begin
					r_d.acc = `CKU_ACC_PRESET;
				end
				// A start carries its own preset, so a preset bit beside it is moot
				if (take_start) begin
					r_d.acc   = `CKU_ACC_PRESET;
					r_d.scan  = 1'b1;
					r_d.faddr = `CKU_SCAN_START_ADDR;
					r_d.rem   = scan_len;
					r_d.st    = CKU_FETCH;
				end else if (take_byte) begin
					r_d.sh      = sfr_req.wdata;
					r_d.bit_cnt = 3'h0;
					r_d.st      = CKU_SHIFT;
				end
			end
			CKU_FETCH: begin
				// Flash answers one cycle after the address settles
				r_d.st = CKU_LOAD;
			end
			CKU_LOAD: begin
				// First byte of a scan; later bytes load on the last shift
				r_d.sh      = flash_rdata;
				r_d.faddr   = r_q.faddr + 16'h0001;
				r_d.rem     = r_q.rem - 17'h00001;
				r_d.bit_cnt = 3'h0;
				r_d.st      = CKU_SHIFT;
			end
			CKU_SHIFT: begin
				// One bit per clock, eight clocks per byte
				r_d.acc     = step_crc;
				r_d.sh      = {r_q.sh[6:0], 1'b0};
				r_d.bit_cnt = r_q.bit_cnt + 3'h1;
				if (byte_done) begin
					if (more_bytes) begin
						// Next address has been stable for eight clocks already
						r_d.sh    = flash_rdata;
						r_d.faddr = r_q.faddr + 16'h0001;
						r_d.rem   = r_q.rem - 17'h00001;
					end else begin
						r_d.scan = 1'b0;
						r_d.st   = CKU_IDLE;
					end
				end
			end
			default: begin
				// Unused code falls back to idle and releases the CPU
				r_d.st   = CKU_IDLE;
				r_d.scan = 1'b0;
			end
		endcase
	end

	// State register; clock enable freezes everything
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Accumulator wakes preset, as after a written preset bit
			r_q.st      <= CKU_IDLE;
			r_q.scan    <= 1'b0;
			r_q.bit_cnt <= 3'h0;
			r_q.sh      <= 8'h00;
			r_q.acc     <= `CKU_ACC_PRESET;
			r_q.idx     <= `CKU_INDEX_RESET;
			r_q.faddr   <= `CKU_SCAN_START_ADDR;
			r_q.rem     <= 17'h00000;
			r_q.rdata   <= 8'h00;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	// Outputs
	assign sfr_rdata       = r_q.rdata;
	assign flash_req = '{
		rd_en: r_q.scan,
		addr:  r_q.faddr
	};
	assign cpu_idle  = r_q.scan;

endmodule // cku_top
`default_nettype wire

// file: testbench/cku_assertions.sv
// Checker of the checksum unit port behaviour
`timescale 1ns/100ps
`default_nettype none
module cku_assertions
	import cku_pkg::*;
(
	input wire logic           clk,
	input wire logic           rst_b,
	input wire logic           ce,
	input wire cku_sfr_req_t   sfr_req,
	input wire logic     [7:0] sfr_rdata,
	input wire cku_flash_req_t flash_req,
	input wire logic           cpu_idle
);
	logic       rd_t;
	logic       st_t;
	logic [3:0] qc_q;
	// Taken read and taken start strobe
	assign rd_t = ce && sfr_req.rd;
	assign st_t = ce && sfr_req.wr && sfr_req.addr == 8'hEF && sfr_req.wdata[0];
	// Cycles since a window write; a fold in flight refuses a start
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) qc_q <= 4'hF;
		else if (ce && sfr_req.wr && sfr_req.addr == 8'hFD) qc_q <= 4'h0;
		else if (ce && qc_q != 4'hF) qc_q <= qc_q + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_start; st_t && !cpu_idle && qc_q > 4'h9 |=> cpu_idle && flash_req.rd_en; endproperty
	a_start: assert property (p_start) else $error("scan did not start");
	property p_cause; $rose(cpu_idle) |-> $past(st_t); endproperty
	a_cause: assert property (p_cause) else $error("idle without start");
	property p_addr0; $rose(cpu_idle) |-> flash_req.addr == 16'h0000
		##1 flash_req.addr == 16'h0000 ##1 flash_req.addr == 16'h0001; endproperty
	a_addr0: assert property (p_addr0) else $error("scan start address");
	property p_step; cpu_idle && ce && $changed(flash_req.addr) && flash_req.addr != 16'h0000
		|=> $stable(flash_req.addr)[*7]
		##1 (!cpu_idle || flash_req.addr == $past(flash_req.addr) + 16'h0001); endproperty
	a_step: assert property (p_step) else $error("scan byte pace");
	property p_unmap; rd_t && !(sfr_req.addr inside {8'hEF, 8'hFC, 8'hFD}) |=> sfr_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_ctl; rd_t && sfr_req.addr == 8'hEF |=> sfr_rdata == {7'h00, $past(cpu_idle)}; endproperty
	a_ctl: assert property (p_ctl) else $error("control read wrong");
	property p_hold; !rd_t |=> $stable(sfr_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_busy; $rose(cpu_idle) |-> cpu_idle[*8]; endproperty
	a_busy: assert property (p_busy) else $error("scan ended early");
	c_start: cover property (st_t);
	c_scan: cover property ($rose(cpu_idle));
	c_win: cover property (rd_t && sfr_req.addr == 8'hFD);
endmodule // cku_assertions
`default_nettype wire

// file: testbench/cku_flash_model.sv
// Synchronous program flash model for the scan port
`timescale 1ns/100ps
`default_nettype none
module cku_flash_model (
	input  wire logic        clk,
	input  wire logic        rd_en,
	input  wire logic [15:0] addr,
	output logic      [7:0]  rdata
);
	initial rdata = 8'hA5;
	// Byte of addr a cycle later; unread it flips, so no stale byte looks valid
	always @(posedge clk) begin
		if (rd_en) rdata <= addr[7:0] ^ addr[15:8] ^ 8'h5A;
		else rdata <= ~rdata;
	end
endmodule // cku_flash_model
`default_nettype wire

// file: testbench/testbench.sv
// Bench of the checksum unit: registers, data mode and scan start
`timescale 1ns/100ps
`default_nettype none
module testbench
	import cku_pkg::*;
;
	logic           clk = 1'b0;
	logic           rst_b;
	logic           ce;
	logic           pend = 1'b0;
	logic     [1:0] sz;
	logic     [7:0] rdata;
	logic     [7:0] fdat;
	logic           idle;
	logic    [31:0] lf;
	logic    [31:0] crc;
	logic     [7:0] q[$];
	int             num_errors;
	int             check_count;
	cku_sfr_req_t   req;
	cku_flash_req_t freq;
	cku_top i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .sfr_req(req), .sfr_rdata(rdata),
		.app_area_size_field(sz), .flash_req(freq), .flash_rdata(fdat), .cpu_idle(idle));
	cku_flash_model i_fl (.clk(clk), .rd_en(freq.rd_en), .addr(freq.addr), .rdata(fdat));
	always #12.5 clk = ~clk;
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Reference fold, MSB first, no reflection
	function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] b);
		for (int i = 7; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? 32'h04C11DB7 : 32'h0);
		return c;
	endfunction
	task automatic chk(logic [7:0] s, logic [7:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cy(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Each strobe lasts one cycle, then one idle cycle
	task automatic wr(logic [7:0] a, logic [7:0] d);
		req = '{1'b1, 1'b0, a, d};
		cy(1);
		req.wr = 1'b0;
		cy(1);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		req = '{1'b0, 1'b1, a, 8'h00};
		q.push_back(e);
		cy(1);
		req.rd = 1'b0;
		cy(1);
	endtask
	task conclude();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Read data is settled one cycle after the taking edge
	always @(posedge clk) begin
		if (pend) chk(rdata, q.pop_front());
		pend <= rst_b && ce && req.rd;
	end
	initial begin
		rst_b = 0; ce = 1; sz = 2'h0; req = '0;
		lf = 32'h4BD04BEE; num_errors = 0; check_count = 0;
		cy(2);
		rst_b = 1'b1;
		rd(8'hFC, 8'h00);
		rd(8'hEF, 8'h00);
		rd(8'h80, 8'h00);
		rd(8'hFD, 8'hFF);
		$display("test reset values done");
		wr(8'hEF, 8'h02);
		crc = 32'hFFFFFFFF;
		for (int i = 0; i < 12; i++) begin
			lf = nxt(lf);
			wr(8'hFD, lf[7:0]);
			wr(8'hFD, lf[15:8]); // Refused, fold still busy
			crc = fold(crc, lf[7:0]);
			ce = i[0];
			cy(3);
			ce = 1'b1;
			cy(8);
		end
		wr(8'hFC, 8'h00);
		for (int i = 0; i < 5; i++) rd(8'hFD, crc[8*(i%4) +: 8]);
		rd(8'hFC, 8'h01);
		wr(8'hEF, 8'h02);
		rd(8'hFD, 8'hFF);
		wr(8'hEF, 8'h00);
		rd(8'hEF, 8'h00);
		$display("test data mode done");
		lf = nxt(lf);
		sz = lf[1:0];
		wr(8'hEF, 8'h03);
		for (int n = 0; n < 20 && idle !== 1'b1; n++) cy(1);
		chk({7'h00, idle}, 8'h01);
		if (idle !== 1'b1) conclude();
		rd(8'hEF, 8'h01);
		wr(8'hFD, 8'h3C);
		cy(200);
		chk({7'h00, freq.rd_en}, 8'h01);
		rst_b = 1'b0;
		cy(2);
		rst_b = 1'b1;
		chk({7'h00, idle}, 8'h00);
		rd(8'hFD, 8'hFF);
		$display("test scan start done");
		conclude();
	end
endmodule // testbench
bind cku_top cku_assertions i_chk (.clk(clk), .rst_b(rst_b), .ce(ce), .sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata), .flash_req(flash_req), .cpu_idle(cpu_idle));
`default_nettype wire
